// File: verilog/wake_defines.svh
/*
  constants of the idle wake-up link: parameter block layout, source bit
  positions, timer figures and the host controller register map.
  assumes inclusion by bare name from the device, host, checker and bench files.
*/
`ifndef WAKE_DEFINES_SVH
`define WAKE_DEFINES_SVH

`define IDLE_BLOCK_BYTES 16
`define IDLE_SRC_IDX 4'h2
`define IDLE_LIMIT_IDX 4'h3
`define IDLE_IVL_IDX 4'h4
`define IDLE_LAST_IDX 4'hf

`define SRC_OSC_HI 7
`define SRC_OSC_LO 6
`define SRC_RSVD 5
`define SRC_SELPIN 4
`define SRC_WAKEPIN 3
`define SRC_FIELD 2
`define SRC_TAG 1
`define SRC_TIMER 0

`define PCLK_HZ 20000000
`define SLOW_HZ_FAST 32000
`define REF_TICK_PERIODS 256
`define LIMIT_MIN 5'h01
`define LIMIT_MAX 5'h1e

`define RSEL_SOURCE 1'b0
`define RSEL_EVENT 1'b1

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_STATUS 8'h08
`define REG_IRQ_CLEAR 8'h0c
`define REG_IRQ_ENABLE 8'h10

`define CTRL_LIMIT_LO 8
`define CTRL_IVL_LO 16
`define CTRL_GO_IDLE 24
`define CTRL_GO_READ 25
`define CTRL_READ_SEL 26
`define CTRL_TAG_CAL 27
`define CTRL_SEL_LOW 28
`define CTRL_WAKE_LOW 29

`define IRQ_IDLE_DONE 0
`define IRQ_READ_DONE 1
`define IRQ_BITS 2

`endif

// File: verilog/wake_pkg.sv
/*
  types shared by both ends of the idle wake-up link.
  assumes wake_defines.svh for all numeric constants.
*/
package wake_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [4:0] limit_t;
  typedef enum logic [1:0] {
    DEV_READY = 2'b00,
    DEV_RECV = 2'b01,
    DEV_WAIT = 2'b11,
    DEV_RESP = 2'b10
  } dev_state_t;
  typedef enum logic [1:0] {
    HOST_IDLE = 2'b00,
    HOST_SEND = 2'b01,
    HOST_WAIT = 2'b11,
    HOST_RDWAIT = 2'b10
  } host_state_t;
endpackage

// File: verilog/idle_link.sv
/*
  link between host controller and wake-up device: byte command stream,
  register read request, one-cycle response and the two wake pins.
  assumes both ends run on the same pclk.
*/
`timescale 1ns/1ps
interface idle_link;
  logic cmd_valid;
  logic cmd_ready;
  wake_pkg::byte_t cmd_byte;
  logic rd_req;
  logic rd_sel;
  logic resp_valid;
  logic resp_is_idle;
  wake_pkg::byte_t resp_byte;
  logic sel_pin_n;
  logic wake_pin_n;
  modport device (
    input cmd_valid, cmd_byte, rd_req, rd_sel, sel_pin_n, wake_pin_n,
    output cmd_ready, resp_valid, resp_is_idle, resp_byte
  );
  modport host (
    output cmd_valid, cmd_byte, rd_req, rd_sel, sel_pin_n, wake_pin_n,
    input cmd_ready, resp_valid, resp_is_idle, resp_byte
  );
endinterface

// File: verilog/wake_device.sv
/*
  wake-up device end: takes the sixteen-byte idle parameter block, holds
  the source register, sleeps in the wait-for-event state with a slow
  oscillator model and records the wake cause.
  assumes a host on idle_link.host and detector levels from the analogue side.
  // Contract
  // (R01) source byte is third of sixteen
  // (R02) idle stores oscillator rate and mask
  // (R03) cause register updated on leaving wait
  // (R04) cause returned in idle reply, register read
  // (R05) bits 7:6 pick 32/16/8/4 kHz
  // (R06) bit 4: low select pin wakes
  // (R07) bit 3: low wake pin wakes
  // (R08) bit 2: field detection wakes
  // (R09) bit 1: tag detection wakes
  // (R10) host sets tag bit for detection runs
  // (R11) bit 0: timeout returns to ready
  // (R12) timeout (limit+1)*(interval+2)*reference tick
  // (R13) reference tick is 256 slow periods
  // (R14) host keeps limit between 0x00 and 0x1f
  // (R15) host sets timeout bit for calibration, timer
  // (R16) reserved bit 5 written zero, ignored
*/
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "wake_defines.svh"
module wake_device #(
  parameter int SLOW_DIV = `PCLK_HZ / `SLOW_HZ_FAST,
  parameter int REF_PERIODS = `REF_TICK_PERIODS
) (
  input wire logic pclk,
  input wire logic presetn,
  idle_link.device lnk,
  input wire logic field_detect,
  input wire logic tag_detect,
  output logic in_wait_state,
  output wake_pkg::byte_t source_cfg,
  output wake_pkg::byte_t wake_cause
);
  import wake_pkg::*;

  dev_state_t state_q;
  logic [3:0] idx_q;
  byte_t src_q, cause_q, limit_q, ivl_q;
  byte_t resp_q;
  logic resp_v_q, resp_idle_q;
  logic [1:0] sel_sync_q, wake_sync_q, fld_sync_q, tag_sync_q;
  logic [18:0] slow_cnt_q;
  logic [15:0] ref_cnt_q;
  byte_t ivl_cnt_q, cyc_cnt_q;
  logic slow_tick, ref_tick, ivl_done, timeout_hit;
  logic [4:0] hits;
  logic wake;

  // pins and detector levels are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_sync_q <= 2'h3;
      wake_sync_q <= 2'h3;
      fld_sync_q <= 2'h0;
      tag_sync_q <= 2'h0;
    end else begin
      sel_sync_q <= {sel_sync_q[0], lnk.sel_pin_n};
      wake_sync_q <= {wake_sync_q[0], lnk.wake_pin_n};
      fld_sync_q <= {fld_sync_q[0], field_detect};
      tag_sync_q <= {tag_sync_q[0], tag_detect};
    end
  end

  function automatic logic [18:0] slow_period(input logic [1:0] code);
    // each step of the code halves the oscillator rate
    slow_period = 19'(SLOW_DIV) << code; // [R05]
  endfunction

  always_comb begin
    hits = '0;
    hits[`SRC_SELPIN] = src_q[`SRC_SELPIN] & ~sel_sync_q[1]; // [R06]
    hits[`SRC_WAKEPIN] = src_q[`SRC_WAKEPIN] & ~wake_sync_q[1]; // [R07]
    hits[`SRC_FIELD] = src_q[`SRC_FIELD] & fld_sync_q[1]; // [R08]
    hits[`SRC_TAG] = src_q[`SRC_TAG] & tag_sync_q[1]; // [R09]
    hits[`SRC_TIMER] = src_q[`SRC_TIMER] & timeout_hit; // [R11]
  end

  assign wake = (state_q == DEV_WAIT) && (hits != 5'h00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= DEV_READY;
      idx_q <= 4'h0;
    end else begin
      unique case (state_q)
        DEV_READY: begin
          if (lnk.cmd_valid) begin
            state_q <= DEV_RECV;
            idx_q <= 4'h1;
          end
        end
        DEV_RECV: begin
          if (lnk.cmd_valid) begin
            idx_q <= idx_q + 4'h1;
            if (idx_q == `IDLE_LAST_IDX) begin
              state_q <= DEV_WAIT; // [R01]
            end
          end
        end
        DEV_WAIT: begin
          if (wake) begin
            state_q <= DEV_RESP;
          end
        end
        DEV_RESP: state_q <= DEV_READY;
      endcase
    end
  end

  // parameter block capture; byte 0 is taken in the ready state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= 8'h00;
      limit_q <= 8'h00;
      ivl_q <= 8'h00;
    end else if (lnk.cmd_valid && state_q == DEV_RECV) begin
      if (idx_q == `IDLE_SRC_IDX) begin
        src_q <= lnk.cmd_byte & ~(8'h01 << `SRC_RSVD); // [R02] [R16]
      end
      if (idx_q == `IDLE_LIMIT_IDX) begin
        limit_q <= lnk.cmd_byte;
      end
      if (idx_q == `IDLE_IVL_IDX) begin
        ivl_q <= lnk.cmd_byte;
      end
    end
  end

  // sleep timer, counted only inside the wait state
  assign slow_tick = slow_cnt_q == slow_period(src_q[`SRC_OSC_HI:`SRC_OSC_LO]) - 19'h1;
  assign ref_tick = slow_tick && (ref_cnt_q == 16'(REF_PERIODS - 1)); // [R13]
  assign ivl_done = ref_tick && (ivl_cnt_q == ivl_q + 8'h1);
  assign timeout_hit = ivl_done && (cyc_cnt_q == limit_q); // [R12]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_cnt_q <= '0;
      ref_cnt_q <= '0;
      ivl_cnt_q <= 8'h00;
      cyc_cnt_q <= 8'h00;
    end else if (state_q != DEV_WAIT) begin
      slow_cnt_q <= '0;
      ref_cnt_q <= '0;
      ivl_cnt_q <= 8'h00;
      cyc_cnt_q <= 8'h00;
    end else begin
      slow_cnt_q <= slow_tick ? '0 : slow_cnt_q + 19'h1;
      if (slow_tick) begin
        ref_cnt_q <= ref_tick ? '0 : ref_cnt_q + 16'h1;
      end
      if (ref_tick) begin
        ivl_cnt_q <= ivl_done ? 8'h00 : ivl_cnt_q + 8'h1;
      end
      if (ivl_done) begin
        cyc_cnt_q <= cyc_cnt_q + 8'h1;
      end
    end
  end

  // cause keeps the rate code so software sees both in one byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= 8'h00;
    end else if (wake) begin
      cause_q <= {src_q[`SRC_OSC_HI:`SRC_OSC_LO], 1'b0, hits}; // [R03]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_v_q <= 1'b0;
      resp_idle_q <= 1'b0;
      resp_q <= 8'h00;
    end else begin
      resp_v_q <= 1'b0;
      resp_idle_q <= 1'b0;
      if (state_q == DEV_RESP) begin
        resp_v_q <= 1'b1;
        resp_idle_q <= 1'b1;
        resp_q <= cause_q; // [R04]
      // rd_req stays up until the host sees the reply: answer it once only
      end else if (state_q == DEV_READY && lnk.rd_req && !lnk.cmd_valid && !resp_v_q) begin
        resp_v_q <= 1'b1;
        resp_q <= (lnk.rd_sel == `RSEL_EVENT) ? cause_q : src_q; // [R04]
      end
    end
  end

  assign lnk.cmd_ready = (state_q == DEV_READY) || (state_q == DEV_RECV);
  assign lnk.resp_valid = resp_v_q;
  assign lnk.resp_is_idle = resp_idle_q;
  assign lnk.resp_byte = resp_q;
  assign in_wait_state = state_q == DEV_WAIT;
  assign source_cfg = src_q;
  assign wake_cause = cause_q;
endmodule

// File: verilog/wake_host.sv
/*
  host controller end: APB register slave that builds and sends the idle
  parameter block, issues register reads, drives the wake pins and raises
  an interrupt on each reply.
  assumes an APB master on pclk and the device on idle_link.device.
*/
`timescale 1ns/1ps
`include "wake_defines.svh"
module wake_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  idle_link.host lnk
);
  import wake_pkg::*;

  host_state_t state_q;
  byte_t src_q, ivl_q, resp_q;
  limit_t limit_q;
  logic tag_cal_q, rd_sel_q, sel_low_q, wake_low_q;
  logic [3:0] idx_q;
  logic [`IRQ_BITS-1:0] irq_stat_q, irq_en_q, irq_set;
  logic wr, go_idle, go_read;
  byte_t src_out, byte_out;
  limit_t limit_out;

  assign wr = psel && penable && pwrite;
  assign go_idle = wr && paddr == `REG_CTRL && pwdata[`CTRL_GO_IDLE] && state_q == HOST_IDLE;
  assign go_read = wr && paddr == `REG_CTRL && pwdata[`CTRL_GO_READ] && !pwdata[`CTRL_GO_IDLE]
                   && state_q == HOST_IDLE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= 8'h00;
      limit_q <= `LIMIT_MIN;
      ivl_q <= 8'h00;
      tag_cal_q <= 1'b0;
      rd_sel_q <= 1'b0;
      sel_low_q <= 1'b0;
      wake_low_q <= 1'b0;
    end else if (wr && paddr == `REG_CTRL && state_q == HOST_IDLE) begin
      src_q <= pwdata[7:0];
      limit_q <= pwdata[`CTRL_LIMIT_LO +: 5];
      ivl_q <= pwdata[`CTRL_IVL_LO +: 8];
      tag_cal_q <= pwdata[`CTRL_TAG_CAL];
      rd_sel_q <= pwdata[`CTRL_READ_SEL];
      sel_low_q <= pwdata[`CTRL_SEL_LOW];
      wake_low_q <= pwdata[`CTRL_WAKE_LOW];
    end
  end

  // calibration forces tag and timer sources; reserved bit sent as zero
  always_comb begin
    src_out = src_q & ~(8'h01 << `SRC_RSVD); // [R16]
    if (tag_cal_q) begin
      src_out = src_out | (8'h01 << `SRC_TAG) | (8'h01 << `SRC_TIMER); // [R10] [R15]
    end
    limit_out = limit_q;
    if (limit_q < `LIMIT_MIN) begin
      limit_out = `LIMIT_MIN; // [R14]
    end else if (limit_q > `LIMIT_MAX) begin
      limit_out = `LIMIT_MAX; // [R14]
    end
    unique case (idx_q)
      `IDLE_SRC_IDX: byte_out = src_out; // [R01]
      `IDLE_LIMIT_IDX: byte_out = {3'h0, limit_out};
      `IDLE_IVL_IDX: byte_out = ivl_q;
      default: byte_out = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= HOST_IDLE;
      idx_q <= 4'h0;
    end else begin
      unique case (state_q)
        HOST_IDLE: begin
          idx_q <= 4'h0;
          if (go_idle) begin
            state_q <= HOST_SEND;
          end else if (go_read) begin
            state_q <= HOST_RDWAIT;
          end
        end
        HOST_SEND: begin
          if (lnk.cmd_ready) begin
            idx_q <= idx_q + 4'h1;
            if (idx_q == `IDLE_LAST_IDX) begin
              state_q <= HOST_WAIT;
            end
          end
        end
        HOST_WAIT, HOST_RDWAIT: begin
          if (lnk.resp_valid) begin
            state_q <= HOST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_q <= 8'h00;
    end else if (lnk.resp_valid) begin
      resp_q <= lnk.resp_byte;
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set[`IRQ_IDLE_DONE] = lnk.resp_valid && lnk.resp_is_idle;
    irq_set[`IRQ_READ_DONE] = lnk.resp_valid && !lnk.resp_is_idle;
  end

  // a reply arriving with its clear keeps its bit set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
      irq_en_q <= '0;
    end else begin
      if (wr && paddr == `REG_IRQ_CLEAR) begin
        irq_stat_q <= (irq_stat_q & ~pwdata[`IRQ_BITS-1:0]) | irq_set;
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
      if (wr && paddr == `REG_IRQ_ENABLE) begin
        irq_en_q <= pwdata[`IRQ_BITS-1:0];
      end
    end
  end

  always_comb begin
    unique case (paddr)
      `REG_CTRL: prdata = {2'h0, wake_low_q, sel_low_q, tag_cal_q, rd_sel_q, 2'h0, ivl_q,
                           3'h0, limit_q, src_q};
      `REG_STATUS: prdata = {23'h0, state_q != HOST_IDLE, resp_q};
      `REG_IRQ_STATUS: prdata = {30'h0, irq_stat_q};
      `REG_IRQ_ENABLE: prdata = {30'h0, irq_en_q};
      default: prdata = 32'h0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign irq = |(irq_stat_q & irq_en_q);
  assign lnk.cmd_valid = state_q == HOST_SEND;
  assign lnk.cmd_byte = byte_out;
  assign lnk.rd_req = state_q == HOST_RDWAIT;
  assign lnk.rd_sel = rd_sel_q;
  assign lnk.sel_pin_n = ~sel_low_q; // [R06]
  assign lnk.wake_pin_n = ~wake_low_q; // [R07]
endmodule

// File: sim/wake_chk.sv
/* checker for the idle link between host and wake device.
   assumes instantiation in tb beside the interface, same pclk. */
`timescale 1ns/1ps
`include "wake_defines.svh"
module wake_chk #(
  parameter int SLOW_DIV = `PCLK_HZ / `SLOW_HZ_FAST,
  parameter int REF_PERIODS = `REF_TICK_PERIODS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire wake_pkg::byte_t cmd_byte,
  input wire logic rd_req,
  input wire logic rd_sel,
  input wire logic resp_valid,
  input wire logic resp_is_idle,
  input wire wake_pkg::byte_t resp_byte,
  input wire logic sel_pin_n,
  input wire logic wake_pin_n
);
  import wake_pkg::*;
  logic [3:0] idx_q;
  byte_t src_q, lim_q, ivl_q;
  logic wt_q;
  int wcnt_q;
  int tmo;
  int per;
  wire take = cmd_valid & cmd_ready;
  assign per = SLOW_DIV << src_q[7:6];
  assign tmo = (int'(lim_q) + 1) * (int'(ivl_q) + 2) * REF_PERIODS * per;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_q <= 4'h0;
      src_q <= 8'h00;
      lim_q <= 8'h00;
      ivl_q <= 8'h00;
    end else if (take) begin
      idx_q <= idx_q + 4'h1;
      if (idx_q == `IDLE_SRC_IDX) src_q <= cmd_byte;
      if (idx_q == `IDLE_LIMIT_IDX) lim_q <= cmd_byte;
      if (idx_q == `IDLE_IVL_IDX) ivl_q <= cmd_byte;
    end
  end
  // wait window: from last byte taken to the idle reply
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wt_q <= 1'b0;
      wcnt_q <= 0;
    end else if (take && idx_q == `IDLE_LAST_IDX) begin
      wt_q <= 1'b1;
      wcnt_q <= 0;
    end else if (resp_valid) begin
      wt_q <= 1'b0;
    end else if (wt_q) begin
      wcnt_q <= wcnt_q + 1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_idle_flag;
    resp_is_idle |-> resp_valid;
  endproperty
  a_idle_flag: assert property (p_idle_flag) else $error("idle flag alone");
  property p_resp_pulse;
    resp_valid |=> !resp_valid;
  endproperty
  a_resp_pulse: assert property (p_resp_pulse) else $error("reply too long");
  property p_block_len;
    take && idx_q == `IDLE_LAST_IDX |=> !cmd_ready;
  endproperty
  a_block_len: assert property (p_block_len) else $error("17th byte taken");
  property p_busy;
    wt_q && !resp_valid |-> !cmd_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("bytes taken in wait");
  property p_wakepin;
    wt_q && !resp_valid && !wake_pin_n && src_q[`SRC_WAKEPIN] |-> ##[1:6] resp_valid;
  endproperty
  a_wakepin: assert property (p_wakepin) else $error("wake pin ignored");
  property p_selpin;
    wt_q && !resp_valid && !sel_pin_n && src_q[`SRC_SELPIN] |-> ##[1:6] resp_valid;
  endproperty
  a_selpin: assert property (p_selpin) else $error("select pin ignored");
  property p_rate;
    resp_is_idle |-> resp_byte[7:6] == src_q[7:6] && !resp_byte[`SRC_RSVD];
  endproperty
  a_rate: assert property (p_rate) else $error("rate field wrong");
  property p_mask;
    resp_is_idle |-> (resp_byte[4:0] & ~src_q[4:0]) == 5'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("masked cause seen");
  property p_read;
    $rose(rd_req) |-> ##[1:3] (resp_valid && !resp_is_idle);
  endproperty
  a_read: assert property (p_read) else $error("read not answered");
  property p_src_read;
    resp_valid && !resp_is_idle && rd_sel == `RSEL_SOURCE
      |-> resp_byte == {src_q[7:6], 1'b0, src_q[4:0]};
  endproperty
  a_src_read: assert property (p_src_read) else $error("source read wrong");
  property p_timer;
    resp_is_idle && resp_byte[`SRC_TIMER] |-> wcnt_q + 4 >= tmo && wcnt_q <= tmo + per + 8;
  endproperty
  a_timer: assert property (p_timer) else $error("timeout length wrong");
  property p_limit;
    take && idx_q == `IDLE_LIMIT_IDX |-> cmd_byte > 8'h00 && cmd_byte < 8'h1f;
  endproperty
  a_limit: assert property (p_limit) else $error("sleep limit out of range");
  property p_rsvd;
    take && idx_q == `IDLE_SRC_IDX |-> !cmd_byte[`SRC_RSVD];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit sent set");
endmodule

// File: sim/tb.sv
/* bench: host and wake device face each other over idle_link.
   assumes the shortened slow clock SLOW_DIV 2, REF_PERIODS 4. */
`timescale 1ns/1ps
`include "wake_defines.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("Error %0t: got %h exp %h", $time, (a), (b)); end end
module tb;
  import wake_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic field_detect, tag_detect, in_wait_state;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  byte_t source_cfg, wake_cause;
  int fails, total_checks, n;
  idle_link lnk();
  wake_device #(.SLOW_DIV(2), .REF_PERIODS(4)) u_wake_device(.pclk(pclk), .presetn(presetn),
    .lnk(lnk), .field_detect(field_detect), .tag_detect(tag_detect),
    .in_wait_state(in_wait_state), .source_cfg(source_cfg), .wake_cause(wake_cause));
  wake_host u_wake_host(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .lnk(lnk));
  wake_chk #(.SLOW_DIV(2), .REF_PERIODS(4)) u_wake_chk(.pclk(pclk), .presetn(presetn),
    .cmd_valid(lnk.cmd_valid), .cmd_ready(lnk.cmd_ready), .cmd_byte(lnk.cmd_byte),
    .rd_req(lnk.rd_req), .rd_sel(lnk.rd_sel), .resp_valid(lnk.resp_valid),
    .resp_is_idle(lnk.resp_is_idle), .resp_byte(lnk.resp_byte),
    .sel_pin_n(lnk.sel_pin_n), .wake_pin_n(lnk.wake_pin_n));
  task end_sim;
    $display("checks %0d errors %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wait_irq(output int c);
    c = 0;
    while (irq !== 1'b1 && c < 3000) begin
      @(posedge pclk);
      c++;
    end
  endtask
  // pins ride in the same write as go, since ctrl writes are ignored while busy
  task run_idle(input byte_t src, input logic [31:0] pins, input logic [1:0] det,
                input byte_t exp);
    apb(1'b1, `REG_CTRL, pins | 32'h0100_0100 | {24'h0, src});
    n = 0;
    while (in_wait_state !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    `CHK(in_wait_state, 1'b1)
    {tag_detect, field_detect} <= det;
    wait_irq(n);
    `CHK(irq, 1'b1)
    apb(1'b0, `REG_STATUS, 32'h0);
    `CHK(r[7:0], exp)
    `CHK(wake_cause, exp)
    `CHK(source_cfg, ((src & 8'hdf) | (pins[`CTRL_TAG_CAL] ? 8'h03 : 8'h00)))
    {tag_detect, field_detect} <= 2'b00;
    apb(1'b1, `REG_IRQ_CLEAR, 32'h3);
    apb(1'b1, `REG_CTRL, 32'h0);
    `CHK(irq, 1'b0)
  endtask
  task rd_reg(input logic sel, input byte_t exp);
    apb(1'b1, `REG_CTRL, 32'h0200_0000 | (32'(sel) << `CTRL_READ_SEL));
    wait_irq(n);
    `CHK(irq, 1'b1)
    apb(1'b0, `REG_STATUS, 32'h0);
    `CHK(r[7:0], exp)
    apb(1'b1, `REG_IRQ_CLEAR, 32'h3);
  endtask
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    end_sim;
  end
  initial begin
    {presetn, psel, penable, pwrite, field_detect, tag_detect} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fails = 0;
    total_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `REG_IRQ_STATUS, 32'h0);
    `CHK(r, 32'h0)
    apb(1'b0, 8'h14, 32'h0);
    `CHK(r, 32'h0)
    `CHK(pslverr, 1'b0)
    apb(1'b1, `REG_IRQ_ENABLE, 32'h3);
    run_idle(8'h0c, 32'h2000_0000, 2'b00, 8'h08);
    run_idle(8'h50, 32'h1000_0000, 2'b00, 8'h50);
    run_idle(8'h84, 32'h0, 2'b01, 8'h84);
    run_idle(8'hc2, 32'h0, 2'b10, 8'hc2);
    // field held high but masked: only the timer may end the wait
    run_idle(8'h61, 32'h0, 2'b01, 8'h41);
    `CHK(n >= 64 && n <= 76, 1'b1)
    rd_reg(`RSEL_EVENT, 8'h41);
    rd_reg(`RSEL_SOURCE, 8'h41);
    apb(1'b1, `REG_IRQ_ENABLE, 32'h1);
    apb(1'b1, `REG_CTRL, 32'h0200_0000);
    repeat (10) @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b0, `REG_IRQ_STATUS, 32'h0);
    `CHK(r[1:0], 2'b10)
    apb(1'b1, `REG_IRQ_CLEAR, 32'h3);
    apb(1'b0, `REG_IRQ_STATUS, 32'h0);
    `CHK(r[1:0], 2'b00)
    // calibration forces tag and timer; a limit of 0x1f must go out as 0x1e
    run_idle(8'h00, 32'h0800_1f00, 2'b00, 8'h01);
    `CHK(n >= 496 && n <= 508, 1'b1)
    end_sim;
  end
endmodule
